// ---- hdl/hlb_pkg.sv ----
/*
 Shared constants and types for the host list buffer port: command codes,
 buffer sizes, status bit positions and the controller's own register map.
 Assumes both ends run on one clock, mclk, at 100 MHz.
*/
package hlb_pkg;
   // -----------------------------------------------------------------
   // Command codes seen on the link
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_LEN_A_RD = 8'h2d;
   localparam logic [7:0] CMD_LEN_B_RD = 8'h2e;
   localparam logic [7:0] CMD_ISO_RD = 8'h40;
   localparam logic [7:0] CMD_ISO_WR = 8'hc0;
   localparam logic [7:0] CMD_ACK_RD = 8'h41;
   localparam logic [7:0] CMD_ACK_WR = 8'hc1;
   localparam logic [7:0] CMD_XFER_CNT_WR = 8'ha2;
   localparam logic [7:0] CMD_BUF_STATE_RD = 8'h2c;
   localparam logic [7:0] CMD_IRQ_RD = 8'h04;
   localparam logic [7:0] CMD_IRQ_CLR = 8'h84;
   // -----------------------------------------------------------------
   // Buffer geometry and field positions
   // -----------------------------------------------------------------
   localparam int ISO_BYTES = 64;
   localparam int ISO_HALF_BITS = 5;
   localparam int ACK_BYTES = 64;
   localparam int ACK_IDX_BITS = 6;
   localparam logic [15:0] PTR_STEP = 16'h0002;
   localparam int ALL_EOT_BIT = 2;
   localparam int ST_ISO_A_FULL = 0;
   localparam int ST_ISO_B_FULL = 1;
   localparam int ST_ACK_FULL = 2;
   localparam int ST_ISO_A_DONE = 3;
   localparam int ST_ISO_B_DONE = 4;
   localparam int ST_ACK_DONE = 5;
   localparam logic [15:0] LEN_RESET = 16'h0000;
   localparam logic [5:0] STATE_RESET = 6'h00;
   // -----------------------------------------------------------------
   // Controller register map on the software port
   // -----------------------------------------------------------------
   localparam logic [2:0] HOFS_CMD = 3'h0;
   localparam logic [2:0] HOFS_DATA = 3'h1;
   localparam logic [2:0] HOFS_START = 3'h2;
   localparam logic [2:0] HOFS_PORT = 3'h3;
   localparam logic [2:0] HOFS_STATUS = 3'h4;
   localparam logic [7:0] PORT_RESET = 8'h40;
   typedef enum logic [1:0] {
      HLB_IDLE = 2'b00,
      HLB_CNT_CMD = 2'b01,
      HLB_CNT_DATA = 2'b11,
      HLB_PORT_CMD = 2'b10
   } hlb_seq_e;
endpackage

// ---- hdl/hlb_link_if.sv ----
/*
 Link between the processor end and the buffer port end.
 Assumes both ends share mclk; strobes are one cycle and never overlap.
*/
interface hlb_link_if;
   logic cmd_wr;
   logic data_wr;
   logic data_rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport dev (input cmd_wr, input data_wr, input data_rd, input wdata, output rdata);
   modport host (output cmd_wr, output data_wr, output data_rd, output wdata, input rdata);
endinterface

// ---- hdl/hlb_dev.sv ----
/*
 Buffer port end: command decode, transfer counter, auto-stepping pointer,
 the two byte buffers, readback counts, buffer state and end flag.
 Assumes the list engine drives the usr_ inputs on mclk and the processor
 end keeps the command-then-words order on the link.
*/
module hlb_dev (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   hlb_link_if.dev bus,
   input wire logic usr_len_a_ld,
   input wire logic usr_len_b_ld,
   input wire logic [15:0] usr_len_data,
   input wire logic usr_iso_half,
   input wire logic [2:0] usr_done_set,
   output logic usr_eot,
   output logic usr_all_eot_flag,
   output logic [5:0] usr_buf_state
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] cnt;
      logic [15:0] ptr;
      logic active;
      logic half;
      logic [15:0] len_a;
      logic [15:0] len_b;
      logic [5:0] bstate;
      logic eot_flag;
      logic eot_pls;
      logic [15:0] rdata;
      logic [hlb_pkg::ISO_BYTES-1:0][7:0] iso_mem;
      logic [hlb_pkg::ACK_BYTES-1:0][7:0] ack_mem;
   } hlb_dev_s;

   hlb_dev_s st_r;
   hlb_dev_s st_nxt;

   // Byte index inside the isochronous store; the half picks the upper part.
   function automatic logic [hlb_pkg::ISO_HALF_BITS:0] iso_idx(input logic half, input logic [15:0] p);
      iso_idx = {half, p[hlb_pkg::ISO_HALF_BITS-1:0]};
   endfunction

   function automatic logic [hlb_pkg::ACK_IDX_BITS-1:0] ack_idx(input logic [15:0] p);
      ack_idx = p[hlb_pkg::ACK_IDX_BITS-1:0];
   endfunction

   function automatic logic is_port(input logic [7:0] c);
      is_port = (c == hlb_pkg::CMD_ISO_RD) || (c == hlb_pkg::CMD_ISO_WR) ||
                (c == hlb_pkg::CMD_ACK_RD) || (c == hlb_pkg::CMD_ACK_WR);
   endfunction

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   // One word access per strobe; the end event fires on the access that
   // carries the pointer to or past the count, so an odd count ends on the
   // word holding its last byte.
   always_comb begin
      logic [15:0] p_next;
      logic step;
      logic [5:0] full_sel;
      logic [5:0] done_sel;
      p_next = st_r.ptr + hlb_pkg::PTR_STEP;
      step = 1'b0;
      full_sel = 6'h00;
      done_sel = 6'h00;
      st_nxt = st_r;
      st_nxt.eot_pls = 1'b0;
      if (st_r.cmd == hlb_pkg::CMD_ACK_RD || st_r.cmd == hlb_pkg::CMD_ACK_WR) begin
         full_sel[hlb_pkg::ST_ACK_FULL] = 1'b1;
      end else if (st_r.half) begin
         full_sel[hlb_pkg::ST_ISO_B_FULL] = 1'b1;
      end else begin
         full_sel[hlb_pkg::ST_ISO_A_FULL] = 1'b1;
      end
      // A new port command rewinds the pointer and arms the transfer when the count is nonzero.
      if (bus.cmd_wr) begin
         st_nxt.cmd = bus.wdata[7:0];
         if (is_port(bus.wdata[7:0])) begin
            st_nxt.ptr = 16'h0000;
            st_nxt.active = (st_r.cnt != 16'h0000);
            st_nxt.half = usr_iso_half;
         end
         if (bus.wdata[7:0] == hlb_pkg::CMD_ISO_WR) begin
            done_sel[usr_iso_half ? hlb_pkg::ST_ISO_B_DONE : hlb_pkg::ST_ISO_A_DONE] = 1'b1;
         end
         if (bus.wdata[7:0] == hlb_pkg::CMD_ACK_WR) begin
            done_sel[hlb_pkg::ST_ACK_DONE] = 1'b1;
         end
         st_nxt.bstate = st_r.bstate & ~done_sel;
      end
      if (bus.data_wr) begin
         case (st_r.cmd)
            hlb_pkg::CMD_XFER_CNT_WR: begin
               st_nxt.cnt = bus.wdata;
            end
            hlb_pkg::CMD_IRQ_CLR: begin
               if (bus.wdata[hlb_pkg::ALL_EOT_BIT]) begin
                  st_nxt.eot_flag = 1'b0;
               end
            end
            hlb_pkg::CMD_ISO_WR: begin
               if (st_r.active) begin
                  st_nxt.iso_mem[iso_idx(st_r.half, st_r.ptr)] = bus.wdata[15:8];
                  st_nxt.iso_mem[iso_idx(st_r.half, st_r.ptr | 16'h0001)] = bus.wdata[7:0];
                  step = 1'b1;
               end
            end
            hlb_pkg::CMD_ACK_WR: begin
               if (st_r.active) begin
                  st_nxt.ack_mem[ack_idx(st_r.ptr | 16'h0001)] = bus.wdata[15:8];
                  st_nxt.ack_mem[ack_idx(st_r.ptr)] = bus.wdata[7:0];
                  step = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // Read data is registered and holds from the cycle after the strobe until the next read.
      if (bus.data_rd) begin
         case (st_r.cmd)
            hlb_pkg::CMD_LEN_A_RD: st_nxt.rdata = st_r.len_a;
            hlb_pkg::CMD_LEN_B_RD: st_nxt.rdata = st_r.len_b;
            hlb_pkg::CMD_BUF_STATE_RD: st_nxt.rdata = {10'h000, st_r.bstate};
            hlb_pkg::CMD_IRQ_RD: st_nxt.rdata = {13'h0000, st_r.eot_flag, 2'b00};
            hlb_pkg::CMD_ISO_RD: begin
               if (st_r.active) begin
                  st_nxt.rdata = {st_r.iso_mem[iso_idx(st_r.half, st_r.ptr)],
                                  st_r.iso_mem[iso_idx(st_r.half, st_r.ptr | 16'h0001)]};
                  step = 1'b1;
               end else begin
                  st_nxt.rdata = 16'h0000;
               end
            end
            hlb_pkg::CMD_ACK_RD: begin
               if (st_r.active) begin
                  st_nxt.rdata = {st_r.ack_mem[ack_idx(st_r.ptr | 16'h0001)],
                                  st_r.ack_mem[ack_idx(st_r.ptr)]};
                  step = 1'b1;
               end else begin
                  st_nxt.rdata = 16'h0000;
               end
            end
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
      // Pointer advance and the end-of-transfer event.
      if (step) begin
         st_nxt.ptr = p_next;
         if (p_next >= st_r.cnt) begin
            st_nxt.active = 1'b0;
            st_nxt.eot_flag = 1'b1;
            st_nxt.eot_pls = 1'b1;
            if (bus.data_wr) begin
               st_nxt.bstate = st_r.bstate | full_sel;
            end else begin
               st_nxt.bstate = st_r.bstate & ~full_sel;
            end
         end
      end
      // Engine-side updates; its done marks win over any clear this cycle.
      st_nxt.bstate[5:3] = st_nxt.bstate[5:3] | usr_done_set;
      if (usr_len_a_ld) begin
         st_nxt.len_a = usr_len_data;
      end
      if (usr_len_b_ld) begin
         st_nxt.len_b = usr_len_data;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   // Buffers are not cleared on reset; only control state is.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_r <= st_nxt;
         st_r.cmd <= 8'h00;
         st_r.cnt <= 16'h0000;
         st_r.ptr <= 16'h0000;
         st_r.active <= 1'b0;
         st_r.half <= 1'b0;
         st_r.len_a <= hlb_pkg::LEN_RESET;
         st_r.len_b <= hlb_pkg::LEN_RESET;
         st_r.bstate <= hlb_pkg::STATE_RESET;
         st_r.eot_flag <= 1'b0;
         st_r.eot_pls <= 1'b0;
         st_r.rdata <= 16'h0000;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops.
   assign bus.rdata = st_r.rdata;
   assign usr_eot = st_r.eot_pls;
   assign usr_all_eot_flag = st_r.eot_flag;
   assign usr_buf_state = st_r.bstate;
endmodule // hlb_dev

// ---- hdl/hlb_host.sv ----
/*
 Processor end: turns software register accesses into link commands and
 word accesses, with a small sequencer that loads the byte count and
 issues the port command once.
 Assumes software keeps the strobe rules of the plain register port.
*/
module hlb_host (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   hlb_link_if.host bus,
   input wire logic [2:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [15:0] sw_rdata
);
   typedef struct packed {
      hlb_pkg::hlb_seq_e seq;
      logic [15:0] count;
      logic [7:0] port;
      logic link_rd;
      logic [15:0] rdata;
   } hlb_host_s;

   hlb_host_s st_r;
   hlb_host_s st_nxt;
   logic busy;

   assign busy = (st_r.seq != hlb_pkg::HLB_IDLE);

   // -----------------------------------------------------------------
   // Sequencer and register decode
   // -----------------------------------------------------------------
   // The byte count always goes in before the single port command, so a
   // started transfer cannot run against a stale count.
   always_comb begin
      st_nxt = st_r;
      st_nxt.link_rd = 1'b0;
      bus.cmd_wr = 1'b0;
      bus.data_wr = 1'b0;
      bus.data_rd = 1'b0;
      bus.wdata = 16'h0000;
      case (st_r.seq)
         hlb_pkg::HLB_IDLE: begin
            if (sw_wr && sw_addr == hlb_pkg::HOFS_CMD) begin
               bus.cmd_wr = 1'b1;
               bus.wdata = sw_wdata;
            end
            if (sw_wr && sw_addr == hlb_pkg::HOFS_DATA) begin
               bus.data_wr = 1'b1;
               bus.wdata = sw_wdata;
            end
            if (sw_wr && sw_addr == hlb_pkg::HOFS_PORT) begin
               st_nxt.port = sw_wdata[7:0];
            end
            if (sw_wr && sw_addr == hlb_pkg::HOFS_START) begin
               st_nxt.count = sw_wdata;
               st_nxt.seq = hlb_pkg::HLB_CNT_CMD;
            end
            if (sw_rd && sw_addr == hlb_pkg::HOFS_DATA) begin
               bus.data_rd = 1'b1;
               st_nxt.link_rd = 1'b1;
            end
         end
         hlb_pkg::HLB_CNT_CMD: begin
            bus.cmd_wr = 1'b1;
            bus.wdata = {8'h00, hlb_pkg::CMD_XFER_CNT_WR};
            st_nxt.seq = hlb_pkg::HLB_CNT_DATA;
         end
         hlb_pkg::HLB_CNT_DATA: begin
            bus.data_wr = 1'b1;
            bus.wdata = st_r.count;
            st_nxt.seq = hlb_pkg::HLB_PORT_CMD;
         end
         hlb_pkg::HLB_PORT_CMD: begin
            bus.cmd_wr = 1'b1;
            bus.wdata = {8'h00, st_r.port};
            st_nxt.seq = hlb_pkg::HLB_IDLE;
         end
         default: st_nxt.seq = hlb_pkg::HLB_IDLE;
      endcase
      if (sw_rd) begin
         case (sw_addr)
            hlb_pkg::HOFS_START: st_nxt.rdata = st_r.count;
            hlb_pkg::HOFS_PORT: st_nxt.rdata = {8'h00, st_r.port};
            hlb_pkg::HOFS_STATUS: st_nxt.rdata = {15'h0000, busy};
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_r.seq <= hlb_pkg::HLB_IDLE;
         st_r.count <= 16'h0000;
         st_r.port <= hlb_pkg::PORT_RESET;
         st_r.link_rd <= 1'b0;
         st_r.rdata <= 16'h0000;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Link read data is already a flip-flop in the far end.
   assign sw_rdata = st_r.link_rd ? bus.rdata : st_r.rdata;
endmodule // hlb_host

// ---- testbench/hlb_properties.sv ----
/*
 Checker for the link between the processor end and the buffer port end.
 Assumes the bench instantiates it beside the link interface, on mclk.
*/
module hlb_properties (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cmd_wr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic usr_eot,
   input wire logic usr_all_eot_flag
);
   // -----------------------------------------------------------------
   // Sequences
   // -----------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // The count word follows the count command, then the port command.
   sequence count_then_port;
      data_wr ##1 cmd_wr;
   endsequence
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_strobe_excl: assert property ($onehot0({cmd_wr, data_wr, data_rd}))
      else $error("link strobes overlap");
   a_count_walk: assert property (cmd_wr && wdata[7:0] == hlb_pkg::CMD_XFER_CNT_WR |=> count_then_port)
      else $error("count load not followed by word and port command");
   a_eot_cause: assert property (cmd_wr |=> !usr_eot)
      else $error("end event raised by a command");
   a_eot_orphan: assert property ($rose(usr_eot) |-> $past(data_wr || data_rd))
      else $error("end event rose with no word taken");
   a_eot_sets_flag: assert property (usr_eot |-> usr_all_eot_flag)
      else $error("end event did not set the flag");
   a_eot_single: assert property (usr_eot |=> !usr_eot)
      else $error("end event repeated past the count");
   a_flag_cause: assert property ($rose(usr_all_eot_flag) |-> usr_eot)
      else $error("flag rose without an end event");
   a_rdata_hold: assert property (!$past(data_rd) |-> $stable(rdata))
      else $error("read data moved without a read");
   a_reset_clear: assert property ($fell(sys_rst) |-> rdata == 16'h0000 && !usr_all_eot_flag)
      else $error("state not cleared by reset");
endmodule // hlb_properties

// ---- testbench/tb.sv ----
/*
 Bench for the host list buffer port with both ends joined by the link.
 Assumes the design files compile first; software drives the plain port.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic [2:0] sw_addr = 3'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [15:0] sw_rdata;
   logic len_a_ld = 1'b0;
   logic len_b_ld = 1'b0;
   logic [15:0] len_data = 16'h0000;
   logic iso_half = 1'b0;
   logic [2:0] done_set = 3'h0;
   logic end_of_transfer;
   logic eot_flag;
   logic [5:0] buf_state;
   logic [15:0] v;
   int err_total = 0;
   int samples_checked = 0;
   // -----------------------------------------------------------------
   // Both ends, the link and the checker
   // -----------------------------------------------------------------
   hlb_link_if link ();
   hlb_host hlb_host_inst (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus(link), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   hlb_dev hlb_dev_inst (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus(link), .usr_len_a_ld(len_a_ld),
      .usr_len_b_ld(len_b_ld), .usr_len_data(len_data), .usr_iso_half(iso_half), .usr_done_set(done_set),
      .usr_eot(end_of_transfer), .usr_all_eot_flag(eot_flag), .usr_buf_state(buf_state));
   hlb_properties hlb_properties_inst (.mclk(mclk), .sys_rst(sys_rst), .cmd_wr(link.cmd_wr),
      .data_wr(link.data_wr), .data_rd(link.data_rd), .wdata(link.wdata), .rdata(link.rdata),
      .usr_eot(end_of_transfer), .usr_all_eot_flag(eot_flag));
   // Free-running 100 MHz clock.
   always #5 mclk = ~mclk;
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Each access leaves one idle cycle so a strobe is never set twice in a step.
   task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge mclk);
      sw_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge mclk);
      sw_rd <= 1'b0;
      @(posedge mclk);
      // sw_rdata shows link read data only in the cycle after the strobe, so take it at this edge.
      d = sw_rdata;
   endtask
   task automatic rd_dev(input logic [7:0] code, input logic [15:0] exp);
      sw_write(hlb_pkg::HOFS_CMD, {8'h00, code});
      sw_read(hlb_pkg::HOFS_DATA, v);
      chk(v, exp);
   endtask
   // Clearing the flag first lets every transfer prove it rises only at its end.
   task automatic run_xfer(input logic [7:0] code, input logic [15:0] cnt, input logic [15:0] base,
      input logic [2:0] full);
      sw_write(hlb_pkg::HOFS_CMD, {8'h00, hlb_pkg::CMD_IRQ_CLR});
      sw_write(hlb_pkg::HOFS_DATA, 16'h0004);
      sw_write(hlb_pkg::HOFS_PORT, {8'h00, code});
      sw_write(hlb_pkg::HOFS_START, cnt);
      repeat (3) @(posedge mclk);
      sw_read(hlb_pkg::HOFS_STATUS, v);
      chk(v & 16'h0001, 16'h0000);
      for (int i = 0; i < (32'(cnt) + 1) / 2; i++) begin
         chk({15'h0000, eot_flag}, 16'h0000);
         if (code[7]) sw_write(hlb_pkg::HOFS_DATA, base + 16'(i));
         else begin
            sw_read(hlb_pkg::HOFS_DATA, v);
            chk(v, base + 16'(i));
         end
      end
      chk({15'h0000, eot_flag}, 16'h0001);
      chk({13'h0000, buf_state[2:0]}, {13'h0000, full});
      if (!code[7]) begin
         sw_read(hlb_pkg::HOFS_DATA, v);
         chk(v, 16'h0000);
      end
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
      rd_dev(hlb_pkg::CMD_LEN_A_RD, 16'h0000);
      rd_dev(hlb_pkg::CMD_LEN_B_RD, 16'h0000);
      rd_dev(hlb_pkg::CMD_BUF_STATE_RD, 16'h0000);
      rd_dev(hlb_pkg::CMD_IRQ_RD, 16'h0000);
   endtask
   task automatic t_lengths;
      len_data <= 16'h0006;
      len_a_ld <= 1'b1;
      @(posedge mclk);
      len_a_ld <= 1'b0;
      len_data <= 16'h0004;
      len_b_ld <= 1'b1;
      @(posedge mclk);
      len_b_ld <= 1'b0;
      @(posedge mclk);
      rd_dev(hlb_pkg::CMD_LEN_A_RD, 16'h0006);
      rd_dev(hlb_pkg::CMD_LEN_B_RD, 16'h0004);
   endtask
   // A load pulse while the clock enable is low must be lost.
   task automatic t_freeze;
      ce <= 1'b0;
      len_data <= 16'h00ff;
      len_a_ld <= 1'b1;
      @(posedge mclk);
      len_a_ld <= 1'b0;
      ce <= 1'b1;
      @(posedge mclk);
      rd_dev(hlb_pkg::CMD_LEN_A_RD, 16'h0006);
   endtask
   // Half A then half B round trips, each read count taken from its readback length.
   task automatic t_iso;
      iso_half <= 1'b0;
      run_xfer(hlb_pkg::CMD_ISO_WR, 16'h0006, 16'ha1b0, 3'b001);
      rd_dev(hlb_pkg::CMD_IRQ_RD, 16'h0004);
      rd_dev(hlb_pkg::CMD_LEN_A_RD, 16'h0006);
      run_xfer(hlb_pkg::CMD_ISO_RD, v, 16'ha1b0, 3'b000);
      iso_half <= 1'b1;
      run_xfer(hlb_pkg::CMD_ISO_WR, 16'h0004, 16'hb200, 3'b010);
      rd_dev(hlb_pkg::CMD_LEN_B_RD, 16'h0004);
      run_xfer(hlb_pkg::CMD_ISO_RD, v, 16'hb200, 3'b000);
   endtask
   // An odd read-back count must end on the word holding the last byte.
   task automatic t_ack;
      run_xfer(hlb_pkg::CMD_ACK_WR, 16'h0006, 16'hc300, 3'b100);
      run_xfer(hlb_pkg::CMD_ACK_RD, 16'h0005, 16'hc300, 3'b000);
      sw_read(hlb_pkg::HOFS_START, v);
      chk(v, 16'h0005);
      sw_read(hlb_pkg::HOFS_PORT, v);
      chk(v, {8'h00, hlb_pkg::CMD_ACK_RD});
   endtask
   task automatic t_done;
      done_set <= 3'h7;
      @(posedge mclk);
      done_set <= 3'h0;
      @(posedge mclk);
      rd_dev(hlb_pkg::CMD_BUF_STATE_RD, 16'h0038);
      sw_write(hlb_pkg::HOFS_CMD, {8'h00, hlb_pkg::CMD_ACK_WR});
      chk({13'h0000, buf_state[5:3]}, 16'h0003);
   endtask
   // -----------------------------------------------------------------
   // Run control
   // -----------------------------------------------------------------
   task automatic end_of_test;
      if (err_total == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Main sequence after eight cycles of reset.
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_lengths();
      t_freeze();
      t_iso();
      t_ack();
      t_done();
      end_of_test();
   end
   // The whole run needs well under two thousand cycles.
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      end_of_test();
   end
endmodule // tb
